// *** inc/tscmd_consts.vh ***
// Constants for the temperature sensor command port.
`ifndef TSCMD_CONSTS_VH
`define TSCMD_CONSTS_VH

// Bus address (upper seven bits of the address byte).
`define TSCMD_ADDR          7'h40

// Command bytes.
`define TSCMD_CMD_RESET     8'h7e
`define TSCMD_CMD_CONV_HOLD 8'he3
`define TSCMD_CMD_CONV_FREE 8'hf3
`define TSCMD_CMD_SERA_HI   8'hfa
`define TSCMD_CMD_SERA_LO   8'h0f
`define TSCMD_CMD_SERB_HI   8'hfc
`define TSCMD_CMD_SERB_LO   8'hc9

// Conversion timing.
`define TSCMD_CONV_TIME_US  43000
`define TSCMD_MCLK_MHZ      25
// Conversion length in clock cycles, the product of the two values above.
`define TSCMD_CONV_CYCLES   24'h106738

// Result layout and checksum.
`define TSCMD_STATUS_BITS   2'h0
`define TSCMD_STATUS_W      2
`define TSCMD_CRC_POLY      8'h31
`define TSCMD_CRC_INIT      8'h00

// Readout sources.
`define TSCMD_SRC_NONE      2'h0
`define TSCMD_SRC_TEMP      2'h1
`define TSCMD_SRC_SERA      2'h2
`define TSCMD_SRC_SERB      2'h3

// Byte counts per readout.
`define TSCMD_TEMP_BYTES    4'h3
`define TSCMD_SERA_BYTES    4'h8
`define TSCMD_SERB_BYTES    4'h6
`define TSCMD_SERB_BASE     4'h8
`define TSCMD_BYTE_MAX      4'hf

// Filler and reset values.
`define TSCMD_IDLE_BYTE     8'hff
`define TSCMD_RESULT_RST    16'h0000
`define TSCMD_CNT_RST       24'h000000

`endif

// *** rtl/tscmd_sync.v ***
// Two-stage synchroniser for the bus pins.
`timescale 1ns/1ps
module tscmd_sync #(
  parameter WIDTH = 2
) (
  // Clock and reset
  input  wire             mclk,
  input  wire             rst,
  // Asynchronous in, synchronous out
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg meta;
      reg stable;
      // Idle bus lines are high, so reset to high avoids a false start.
      always @(posedge mclk or posedge rst) begin
        if (rst) begin
          meta   <= 1'b1;
          stable <= 1'b1;
        end else begin
          meta   <= async_in[i];
          stable <= meta;
        end
      end
      assign sync_out[i] = stable;
    end
  endgenerate

endmodule // tscmd_sync

// *** rtl/tscmd_crc8.v ***
// Checksum over the two result bytes.
`timescale 1ns/1ps
`include "tscmd_consts.vh"
module tscmd_crc8 (
  // Data in, checksum out
  input  wire [15:0] data,
  output reg  [7:0]  crc
);

  integer i;

  always @* begin
    crc = `TSCMD_CRC_INIT;
    for (i = 15; i >= 0; i = i - 1) begin
      if (crc[7] ^ data[i]) begin
        crc = {crc[6:0], 1'b0} ^ `TSCMD_CRC_POLY;
      end else begin
        crc = {crc[6:0], 1'b0};
      end
    end
  end

endmodule // tscmd_crc8

// *** rtl/tscmd_top.v ***
// Bus target and command engine of the temperature sensor.
//
// Notes on behaviour
// - Answer and acknowledge at address 1000000x.
// - Decode reset, held conversion, free conversion.
// - Two-byte commands read serial number parts of eight and six bytes.
// - Soft reset accepted at any time except while the clock is held.
// - Busy until conversion done, then result readable.
// - While busy, execute only soft reset.
// - Held mode keeps clock low through conversion.
// - Free mode never drives the clock.
// - Read address refused while busy, acknowledged after.
// - Return high byte, low byte with status, checksum.
// - Sample acknowledge in ninth clock; stop on refusal.
`timescale 1ns/1ps
`include "tscmd_consts.vh"
module tscmd_top #(
  parameter [23:0]  CONV_CYCLES   = `TSCMD_CONV_CYCLES,
  // Arbitrary serial number for the store.
  parameter [111:0] SERIAL_NUMBER = 112'h0102030405060708090a0b0c0d0e
) (
  // Clock and reset
  input  wire        mclk,
  input  wire        rst,
  // Bus pins, open drain
  input  wire        scl_in,
  output reg         scl_out,
  output reg         scl_oe,
  input  wire        sda_in,
  output reg         sda_out,
  output reg         sda_oe,
  // Converter side
  input  wire [15:0] raw_temp_code,
  output reg         conv_start,
  output reg         conv_busy
);

  localparam [6:0] ST_IDLE    = 7'h01;
  localparam [6:0] ST_ADDR    = 7'h02;
  localparam [6:0] ST_WBYTE   = 7'h04;
  localparam [6:0] ST_ACK     = 7'h08;
  localparam [6:0] ST_RBYTE   = 7'h10;
  localparam [6:0] ST_MACK    = 7'h20;
  localparam [6:0] ST_STRETCH = 7'h40;

  wire [1:0]   pins_s;
  wire         scl_s;
  wire         sda_s;
  wire [7:0]   crc;
  wire [111:0] serial_number_store;

  reg  [6:0]   state;
  reg          scl_d;
  reg          sda_d;
  reg  [3:0]   bit_cnt;
  reg  [7:0]   shreg;
  reg  [3:0]   byte_idx;
  reg          is_read;
  reg          ack_flag;
  reg          ack_driven;
  reg          go_stretch;
  reg  [7:0]   cmd_hi;
  reg          hold_mode;
  reg  [23:0]  conv_cnt;
  reg  [15:0]  result;
  reg  [1:0]   rd_src;

  reg  [7:0]   tx_byte;
  reg  [3:0]   ser_idx;
  reg  [111:0] ser_sh;

  wire [7:0] next_rx  = {shreg[6:0], sda_s};
  wire       scl_rise = scl_s & ~scl_d;
  wire       scl_fall = ~scl_s & scl_d;
  wire       start_ev = scl_s & scl_d & sda_d & ~sda_s;
  wire       stop_ev  = scl_s & scl_d & ~sda_d & sda_s;

  assign serial_number_store = SERIAL_NUMBER;

  tscmd_sync #(
    .WIDTH (2)
  ) u_sync (
    .mclk     (mclk),
    .rst      (rst),
    .async_in ({scl_in, sda_in}),
    .sync_out (pins_s)
  );
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  tscmd_crc8 u_crc (
    .data (result),
    .crc  (crc)
  );

  // Byte to send next, chosen by the readout source and byte position.
  always @* begin
    if (rd_src == `TSCMD_SRC_SERB) begin
      ser_idx = byte_idx + `TSCMD_SERB_BASE;
    end else begin
      ser_idx = byte_idx;
    end
    ser_sh = serial_number_store << {ser_idx, 3'h0};
    tx_byte = `TSCMD_IDLE_BYTE;
    case (rd_src)
      `TSCMD_SRC_TEMP: begin
        if (byte_idx == 4'h0) begin
          tx_byte = result[15:8];
        end else if (byte_idx == 4'h1) begin
          tx_byte = result[7:0];
        end else if (byte_idx == 4'h2) begin
          tx_byte = crc;
        end
      end
      `TSCMD_SRC_SERA: begin
        if (byte_idx < `TSCMD_SERA_BYTES) begin
          tx_byte = ser_sh[111:104];
        end
      end
      `TSCMD_SRC_SERB: begin
        if (byte_idx < `TSCMD_SERB_BYTES) begin
          tx_byte = ser_sh[111:104];
        end
      end
      default: begin
        tx_byte = `TSCMD_IDLE_BYTE;
      end
    endcase
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      state      <= ST_IDLE;
      scl_d      <= 1'b1;
      sda_d      <= 1'b1;
      bit_cnt    <= 4'h0;
      shreg      <= 8'h00;
      byte_idx   <= 4'h0;
      is_read    <= 1'b0;
      ack_flag   <= 1'b0;
      ack_driven <= 1'b0;
      go_stretch <= 1'b0;
      cmd_hi     <= 8'h00;
      hold_mode  <= 1'b0;
      conv_cnt   <= `TSCMD_CNT_RST;
      result     <= `TSCMD_RESULT_RST;
      rd_src     <= `TSCMD_SRC_NONE;
      scl_out    <= 1'b0;
      scl_oe     <= 1'b0;
      sda_out    <= 1'b0;
      sda_oe     <= 1'b0;
      conv_start <= 1'b0;
      conv_busy  <= 1'b0;
    end else begin
      scl_d      <= scl_s;
      sda_d      <= sda_s;
      conv_start <= 1'b0;

      // Conversion timer; the result is latched as the busy phase ends.
      if (conv_busy) begin
        conv_cnt <= conv_cnt - 24'h000001;
        if (conv_cnt == 24'h000001) begin
          conv_busy <= 1'b0;
          result    <= {raw_temp_code[15:`TSCMD_STATUS_W], `TSCMD_STATUS_BITS};
          rd_src    <= `TSCMD_SRC_TEMP;
        end
      end

      if (start_ev && state != ST_STRETCH) begin
        state      <= ST_ADDR;
        bit_cnt    <= 4'h0;
        byte_idx   <= 4'h0;
        sda_oe     <= 1'b0;
        go_stretch <= 1'b0;
      end else if (stop_ev && state != ST_STRETCH) begin
        state  <= ST_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            sda_oe <= 1'b0;
          end
          ST_ADDR: begin
            if (scl_rise) begin
              shreg   <= next_rx;
              bit_cnt <= bit_cnt + 4'h1;
              if (bit_cnt == 4'h7) begin
                is_read    <= next_rx[0];
                // Polling a busy device for its result is refused.
                ack_flag   <= (next_rx[7:1] == `TSCMD_ADDR) &&
                              !(next_rx[0] && conv_busy);
                ack_driven <= 1'b0;
                state      <= ST_ACK;
              end
            end
          end
          ST_WBYTE: begin
            if (scl_rise) begin
              shreg   <= next_rx;
              bit_cnt <= bit_cnt + 4'h1;
              if (bit_cnt == 4'h7) begin
                ack_driven <= 1'b0;
                ack_flag   <= 1'b0;
                state      <= ST_ACK;
                if (next_rx == `TSCMD_CMD_RESET) begin
                  ack_flag  <= 1'b1;
                  conv_busy <= 1'b0;
                  conv_cnt  <= `TSCMD_CNT_RST;
                  hold_mode <= 1'b0;
                  rd_src    <= `TSCMD_SRC_NONE;
                  cmd_hi    <= 8'h00;
                end else if (conv_busy) begin
                  ack_flag <= 1'b0;
                  // The address byte is index zero, so the first command byte is index one.
                end else if (byte_idx == 4'h1) begin
                  cmd_hi <= next_rx;
                  if (next_rx == `TSCMD_CMD_CONV_HOLD ||
                      next_rx == `TSCMD_CMD_CONV_FREE) begin
                    ack_flag   <= 1'b1;
                    conv_busy  <= 1'b1;
                    conv_start <= 1'b1;
                    conv_cnt   <= CONV_CYCLES;
                    rd_src     <= `TSCMD_SRC_NONE;
                    hold_mode  <= (next_rx == `TSCMD_CMD_CONV_HOLD);
                    // Free mode leaves the clock alone.
                    go_stretch <= (next_rx == `TSCMD_CMD_CONV_HOLD);
                  end else if (next_rx == `TSCMD_CMD_SERA_HI ||
                               next_rx == `TSCMD_CMD_SERB_HI) begin
                    ack_flag <= 1'b1;
                  end
                end else if (byte_idx == 4'h2) begin
                  if (cmd_hi == `TSCMD_CMD_SERA_HI && next_rx == `TSCMD_CMD_SERA_LO) begin
                    ack_flag <= 1'b1;
                    rd_src   <= `TSCMD_SRC_SERA;
                  end else if (cmd_hi == `TSCMD_CMD_SERB_HI &&
                               next_rx == `TSCMD_CMD_SERB_LO) begin
                    ack_flag <= 1'b1;
                    rd_src   <= `TSCMD_SRC_SERB;
                  end
                end
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if (!ack_driven) begin
                sda_oe     <= ack_flag;
                ack_driven <= 1'b1;
              end else if (!ack_flag) begin
                sda_oe <= 1'b0;
                state  <= ST_IDLE;
              end else if (is_read) begin
                shreg   <= tx_byte;
                sda_oe  <= ~tx_byte[7];
                bit_cnt <= 4'h0;
                state   <= ST_RBYTE;
              end else if (go_stretch) begin
                // The controller owns the clock low here, so taking it is glitch free.
                sda_oe <= 1'b0;
                scl_oe <= 1'b1;
                state  <= ST_STRETCH;
              end else begin
                sda_oe   <= 1'b0;
                bit_cnt  <= 4'h0;
                byte_idx <= byte_idx + 4'h1;
                state    <= ST_WBYTE;
              end
            end
          end
          ST_RBYTE: begin
            if (scl_fall) begin
              if (bit_cnt == 4'h7) begin
                sda_oe <= 1'b0;
                state  <= ST_MACK;
              end else begin
                shreg   <= {shreg[6:0], 1'b0};
                sda_oe  <= ~shreg[6];
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              if (sda_s) begin
                state <= ST_IDLE;
              end else if (byte_idx != `TSCMD_BYTE_MAX) begin
                byte_idx <= byte_idx + 4'h1;
              end
            end else if (scl_fall) begin
              shreg   <= tx_byte;
              sda_oe  <= ~tx_byte[7];
              bit_cnt <= 4'h0;
              state   <= ST_RBYTE;
            end
          end
          ST_STRETCH: begin
            if (!conv_busy) begin
              scl_oe     <= 1'b0;
              go_stretch <= 1'b0;
              state      <= ST_IDLE;
            end
          end
          default: begin
            state  <= ST_IDLE;
            sda_oe <= 1'b0;
            scl_oe <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule // tscmd_top

// *** sim/tscmd_ctl_model.sv ***
// Bus controller model that frames and clocks transfers towards the sensor.
`timescale 1ns/1ps
module tscmd_ctl_model (
  // Clock
  input  wire mclk,
  // Resolved bus levels
  input  wire scl,
  input  wire sda,
  // Controller pulls, high pulls the line low
  output reg  scl_low,
  output reg  sda_low
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  task tick(input integer n);
    repeat (n) @(posedge mclk);
  endtask
  // The target may hold the clock low, so a rise is awaited, not assumed.
  task rise;
    integer n;
    begin
      scl_low <= 1'b0;
      n = 0;
      tick(1);
      while (scl !== 1'b1 && n < 5000) begin
        n = n + 1;
        tick(1);
      end
    end
  endtask
  task bitx(input b, output r);
    begin
      sda_low <= ~b;
      tick(2);
      rise;
      tick(1);
      r = sda;
      tick(2);
      scl_low <= 1'b1;
      tick(2);
    end
  endtask
  task start;
    begin
      sda_low <= 1'b0;
      tick(2);
      rise;
      tick(3);
      sda_low <= 1'b1;
      tick(4);
      scl_low <= 1'b1;
      tick(2);
    end
  endtask
  task stop;
    begin
      sda_low <= 1'b1;
      tick(2);
      rise;
      tick(3);
      sda_low <= 1'b0;
      tick(4);
    end
  endtask
  // Nine clocks with data released free a target that was left inside a byte.
  task recover;
    integer i;
    reg     r;
    begin
      for (i = 0; i < 9; i = i + 1)
        bitx(1'b1, r);
      stop;
    end
  endtask
  task xfer(input [7:0] w, input mack, output [7:0] r, output ack);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1)
        bitx(w[i], r[i]);
      bitx(mack, ack);
    end
  endtask
endmodule // tscmd_ctl_model

// *** sim/tscmd_props.sv ***
// Concurrent checks on the sensor command port pins.
`timescale 1ns/1ps
module tscmd_checker #(
  parameter [23:0] CONV_CYCLES = 24'h0000c8
) (
  // Clock and reset
  input wire        mclk,
  input wire        rst,
  // Bus pins
  input wire        scl_in,
  input wire        scl_out,
  input wire        scl_oe,
  input wire        sda_in,
  input wire        sda_out,
  input wire        sda_oe,
  // Converter side
  input wire [15:0] raw_temp_code,
  input wire        conv_start,
  input wire        conv_busy
);
  reg [23:0] busy_cnt;
  always @(posedge mclk or posedge rst) begin
    if (rst)
      busy_cnt <= 24'h000000;
    else if (conv_busy)
      busy_cnt <= busy_cnt + 24'h000001;
    else
      busy_cnt <= 24'h000000;
  end
  default clocking dc @(posedge mclk); endclocking
  default disable iff (rst);
  start_busy_a: assert property (conv_start |-> ##[0:1] conv_busy)
    else $error("conversion start without busy");
  start_pulse_a: assert property (conv_start |=> !conv_start)
    else $error("conversion start longer than one cycle");
  busy_len_a: assert property (conv_busy |-> busy_cnt < CONV_CYCLES)
    else $error("conversion busy too long");
  busy_refuse_a: assert property (conv_start |-> !$past(conv_busy))
    else $error("conversion restarted while busy");
  hold_cause_a: assert property (scl_oe |-> conv_busy || $past(conv_busy))
    else $error("clock held without conversion");
  hold_steady_a: assert property (scl_oe && conv_busy |=> scl_oe)
    else $error("clock hold dropped during conversion");
  hold_release_a: assert property ($fell(conv_busy) |-> ##[0:2] !scl_oe ##1 !scl_oe)
    else $error("clock not released after conversion");
  hold_quiet_a: assert property (scl_oe |-> !sda_oe)
    else $error("data pulled while clock held");
  open_drain_a: assert property (!scl_out && !sda_out)
    else $error("pin driven high");
endmodule // tscmd_checker
bind tscmd_top tscmd_checker #(.CONV_CYCLES(CONV_CYCLES)) u_chk (
  .mclk(mclk), .rst(rst), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .raw_temp_code(raw_temp_code),
  .conv_start(conv_start), .conv_busy(conv_busy));

// *** sim/tb_temp_sensor_i2c_cmd_port.sv ***
// Self-checking bench for the sensor command port.
`timescale 1ns/1ps
`include "tscmd_consts.vh"
`define CHK(nm, exp, got) begin n_checks = n_checks + 1; \
  if ((got) !== (exp)) begin err_count = err_count + 1; \
  $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module tb_temp_sensor_i2c_cmd_port;
  localparam [23:0]  CONV = 24'h000190;
  localparam [111:0] SER  = 112'h0102030405060708090a0b0c0d0e;
  reg         mclk;
  reg         rst;
  reg  [15:0] raw;
  reg  [7:0]  rb;
  reg  [15:0] got;
  reg         a;
  wire        scl_oe;
  wire        sda_oe;
  wire        conv_busy;
  wire        m_scl;
  wire        m_sda;
  wire        scl_w = ~(scl_oe | m_scl);
  wire        sda_w = ~(sda_oe | m_sda);
  integer     err_count, n_checks, cyc, hcyc;
  tscmd_top #(.CONV_CYCLES(CONV), .SERIAL_NUMBER(SER)) DUT (
    .mclk(mclk), .rst(rst), .scl_in(scl_w), .scl_out(), .scl_oe(scl_oe), .sda_in(sda_w),
    .sda_out(), .sda_oe(sda_oe), .raw_temp_code(raw), .conv_start(), .conv_busy(conv_busy));
  tscmd_ctl_model ctl (.mclk(mclk), .scl(scl_w), .sda(sda_w), .scl_low(m_scl), .sda_low(m_sda));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task final_report;
    begin
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  // A hung handshake ends the run as a mismatch rather than stalling it.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (scl_oe === 1'b1)
      hcyc <= hcyc + 1;
    if (cyc == 30000) begin
      err_count = err_count + 1;
      final_report;
    end
  end
  function [7:0] crc_exp(input [15:0] d);
    integer i;
    begin
      crc_exp = 8'h00;
      for (i = 15; i >= 0; i = i - 1)
        crc_exp = {crc_exp[6:0], 1'b0} ^ ((crc_exp[7] ^ d[i]) ? 8'h31 : 8'h00);
    end
  endfunction
  task send(input [7:0] c0, input [7:0] c1, input two, input ack1);
    begin
      ctl.start;
      ctl.xfer(8'h80, 1'b1, rb, a);
      `CHK("addr ack", 1'b0, a)
      ctl.xfer(c0, 1'b1, rb, a);
      `CHK("cmd ack", ~ack1, a)
      if (two) begin
        ctl.xfer(c1, 1'b1, rb, a);
        `CHK("cmd2 ack", 1'b0, a)
      end
    end
  endtask
  task rdaddr(input ack_exp);
    begin
      ctl.start;
      ctl.xfer(8'h81, 1'b1, rb, a);
      `CHK("read addr ack", ~ack_exp, a)
    end
  endtask
  task rdb(input [7:0] exp, input last);
    begin
      ctl.xfer(8'hff, last, rb, a);
      `CHK("data byte", exp, rb)
    end
  endtask
  task result(input [15:0] v);
    begin
      rdb(v[15:8], 1'b0);
      got[15:8] = rb;
      rdb({v[7:2], 2'b00}, 1'b0);
      got[7:0] = rb & 8'hfc;
      rdb(crc_exp({v[15:2], 2'b00}), 1'b1);
      ctl.stop;
    end
  endtask
  task t_addr;
    begin
      ctl.start;
      ctl.xfer(8'h82, 1'b1, rb, a);
      `CHK("foreign addr", 1'b1, a)
      ctl.stop;
      send(8'h55, 8'h00, 1'b0, 1'b0);
      ctl.stop;
    end
  endtask
  task t_free;
    integer h0;
    begin
      raw <= 16'h8f1e;
      h0 = hcyc;
      send(`TSCMD_CMD_CONV_FREE, 8'h00, 1'b0, 1'b1);
      ctl.stop;
      ctl.recover;
      `CHK("data freed", 1'b1, sda_w)
      `CHK("busy", 1'b1, conv_busy)
      rdaddr(1'b0);
      ctl.stop;
      while (conv_busy === 1'b1)
        ctl.tick(1);
      `CHK("free clock", 1'b1, hcyc == h0)
      rdaddr(1'b1);
      result(16'h8f1e);
      // Hundredths of a degree for the masked code read back.
      `CHK("degrees", 32'h00001412, (got * 32'h000044a4) / 32'h00010000 - 32'h0000124d)
      rdaddr(1'b1);
      rdb(8'h8f, 1'b1);
      rdb(8'hff, 1'b1);
      ctl.stop;
    end
  endtask
  task t_hold;
    integer h0;
    begin
      raw <= 16'h4a73;
      send(`TSCMD_CMD_CONV_HOLD, 8'h00, 1'b0, 1'b1);
      h0 = hcyc;
      rdaddr(1'b1);
      // Busy starts at the command's eighth bit; the hold only after its acknowledge clock.
      `CHK("held clock", 1'b1, (hcyc - h0 > CONV - 14) && (hcyc - h0 <= CONV - 10))
      result(16'h4a73);
    end
  endtask
  task t_reset;
    begin
      send(`TSCMD_CMD_CONV_FREE, 8'h00, 1'b0, 1'b1);
      ctl.stop;
      send(`TSCMD_CMD_CONV_HOLD, 8'h00, 1'b0, 1'b0);
      ctl.stop;
      send(`TSCMD_CMD_RESET, 8'h00, 1'b0, 1'b1);
      ctl.stop;
      `CHK("busy after reset", 1'b0, conv_busy)
      rdaddr(1'b1);
      rdb(8'hff, 1'b1);
      ctl.stop;
    end
  endtask
  task t_serial;
    integer i;
    begin
      send(`TSCMD_CMD_SERA_HI, `TSCMD_CMD_SERA_LO, 1'b1, 1'b1);
      ctl.stop;
      rdaddr(1'b1);
      for (i = 0; i < 8; i = i + 1)
        rdb(SER[111 - 8 * i -: 8], i == 7);
      ctl.stop;
      send(`TSCMD_CMD_SERB_HI, `TSCMD_CMD_SERB_LO, 1'b1, 1'b1);
      ctl.stop;
      rdaddr(1'b1);
      for (i = 8; i < 14; i = i + 1)
        rdb(SER[111 - 8 * i -: 8], i == 13);
      ctl.stop;
    end
  endtask
  initial begin
    rst = 1'b1;
    raw = 16'h0000;
    err_count = 0;
    n_checks = 0;
    cyc = 0;
    hcyc = 0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    t_addr;
    t_free;
    t_hold;
    t_reset;
    t_serial;
    final_report;
  end
endmodule // tb_temp_sensor_i2c_cmd_port
